// ==== iwc_core_model.sv ====
// behavioural processor core that takes and returns interrupts
`timescale 1ns/1ns
module iwc_core_model (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       cpu_irq,
    input  wire       run,
    input  wire [3:0] ack_wait,
    input  wire [7:0] ret_wait,
    output reg        ack,
    output reg        ret
);
    reg [3:0] aw_r;
    reg [7:0] rw_r;
    reg [3:0] pend_r;
    // take a request after ack_wait cycles, return ret_wait cycles later
    always @(posedge clk) begin
        ack <= 1'h0;
        ret <= 1'h0;
        if (!rst_n) begin
            aw_r <= 4'h0;
            rw_r <= 8'h0;
            pend_r <= 4'h0;
        end else if (cpu_irq && run && !ack && aw_r >= ack_wait) begin
            ack <= 1'h1;
            aw_r <= 4'h0;
            rw_r <= ret_wait;
            pend_r <= pend_r + 4'h1;
        end else begin
            aw_r <= (cpu_irq && run && !ack) ? aw_r + 4'h1 : 4'h0;
            if (pend_r != 4'h0 && run) begin
                if (rw_r == 8'h0) begin
                    ret <= 1'h1;
                    pend_r <= pend_r - 4'h1;
                    rw_r <= ret_wait;
                end else begin
                    rw_r <= rw_r - 8'h1;
                end
            end
        end
    end
endmodule

// ==== iwc_defs.vh ====
// constants shared by the interrupt and wake controller files
`ifndef IWC_DEFS_VH
`define IWC_DEFS_VH

// -----------------------------------------------------------------
// sizes
// -----------------------------------------------------------------
`define IWC_NSRC        11
`define IWC_NEXT        8
`define IWC_NLVL        4
`define IWC_LVLW        2
`define IWC_VECW        4

// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define IWC_ADDR_REQ    5'h00
`define IWC_ADDR_EN     5'h04
`define IWC_ADDR_PRIO   5'h08
`define IWC_ADDR_EXTCFG 5'h0C
`define IWC_ADDR_PMCTL  5'h10
`define IWC_ADDR_INSVC  5'h14
`define IWC_ADDR_STAT   5'h18
`define IWC_ADDR_MASK   5'h1C

// -----------------------------------------------------------------
// fields and reset values
// -----------------------------------------------------------------
`define IWC_PM_IDLE     0
`define IWC_PM_STOP     1
`define IWC_ST_WIDLE    0
`define IWC_ST_WSTOP    1
`define IWC_STW         2
`define IWC_EN_RST      11'h000
`define IWC_PRIO_RST    22'h000000
`define IWC_CFG_RST     4'h0
`define IWC_MASK_RST    2'h0

// -----------------------------------------------------------------
// external input sensitivity kinds
// -----------------------------------------------------------------
`define IWC_KIND_LOWFALL 2'h0
`define IWC_KIND_RISEFALL 2'h1
`define IWC_KIND_RISE    2'h2

`endif

// ==== iwc_extint_det.v ====
// one external interrupt input: synchroniser, edge or level detect, flag
`timescale 1ns/1ns
`include "iwc_defs.vh"

module iwc_extint_det #(
    parameter [1:0] KIND = `IWC_KIND_RISE
) (
    input  wire clk,
    input  wire rst_n,
    input  wire pin,
    input  wire sel,
    input  wire clr,
    output wire flag,
    output wire level_mode
);

    reg sync1_r;
    reg sync2_r;
    reg prev_r;
    reg flag_r;
    reg evt;

    // ---------------------------------------------------------------
    // sensitivity decode
    // ---------------------------------------------------------------
    assign level_mode = (KIND == `IWC_KIND_LOWFALL) & sel;

    // event selection per kind
    always @* begin
        case (KIND)
            `IWC_KIND_LOWFALL:  evt = prev_r & ~sync2_r;
            `IWC_KIND_RISEFALL: evt = sel ? (~prev_r & sync2_r)
                                          : (prev_r & ~sync2_r);
            default:            evt = ~prev_r & sync2_r;
        endcase
    end

    // two-stage synchroniser and history, synchronous reset
    always @(posedge clk) begin
        if (!rst_n) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            prev_r  <= 1'b1;
            flag_r  <= 1'b0;
        end else begin
            sync1_r <= pin;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
            if (evt)
                flag_r <= 1'b1; // set wins over clear
            else if (clr)
                flag_r <= 1'b0;
        end
    end

    // level mode follows the input, edge mode is sticky
    assign flag = level_mode ? ~sync2_r : flag_r;

endmodule

// ==== iwc_monitor.sv ====
// assertion checker for the interrupt and wake controller ports
`timescale 1ns/1ns
`include "iwc_defs.vh"
module iwc_monitor #(
    parameter NSRC = 11,
    parameter NEXT = 8,
    parameter VECW = 4
) (
    input wire                 clk,
    input wire                 rst_n,
    input wire [4:0]           address,
    input wire                 read,
    input wire                 write,
    input wire [31:0]          writedata,
    input wire [31:0]          readdata,
    input wire                 waitrequest,
    input wire [NEXT-1:0]      ext_int,
    input wire [NSRC-NEXT-1:0] periph_req,
    input wire                 cpu_irq,
    input wire [VECW-1:0]      cpu_irq_vec,
    input wire                 cpu_irq_ack,
    input wire                 cpu_irq_ret,
    input wire                 cpu_clk_en,
    input wire                 periph_clk_en,
    input wire                 pm_irq
);
    // ------
    // checks
    // ------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // a bus request first waits, then completes
    sequence s_acc_wait;
        (read || write) && waitrequest;
    endsequence
    sequence s_acc_done;
        (read || write) && !waitrequest;
    endsequence
    // a core request not yet taken
    sequence s_irq_open;
        cpu_irq && !cpu_irq_ack;
    endsequence
    a_bus_one_wait: assert property (s_acc_wait |=> s_acc_done)
        else $error("bus access not answered after one wait");
    a_bus_quiet: assert property (!read && !write |-> !waitrequest)
        else $error("waitrequest high with no request");
    a_irq_holds: assert property (s_irq_open |=>
        cpu_irq && $stable(cpu_irq_vec))
        else $error("core request changed before it was taken");
    a_irq_drops: assert property (cpu_irq && cpu_irq_ack |=> !cpu_irq)
        else $error("core request stayed after it was taken");
    a_vec_range: assert property (cpu_irq |-> cpu_irq_vec < NSRC)
        else $error("vector outside the source range");
    a_stop_gates: assert property (!periph_clk_en |-> !cpu_clk_en)
        else $error("core clock runs with peripherals stopped");
    a_reset_quiet: assert property ($rose(rst_n) |-> !cpu_irq
        && cpu_clk_en && periph_clk_en && !pm_irq)
        else $error("outputs not at reset values");
    a_idle_wakes: assert property ($rose(cpu_irq)
        && periph_clk_en |-> cpu_clk_en)
        else $error("core request raised while core is idle");
    a_stat_clear: assert property (read && !waitrequest
        && address == `IWC_ADDR_STAT |=> !pm_irq)
        else $error("status interrupt stayed after status read");
endmodule

// ==== iwc_prio_arb.v ====
// priority request arbiter: level then fixed source order
`timescale 1ns/1ns
`include "iwc_defs.vh"

module iwc_prio_arb #(
    parameter NSRC = `IWC_NSRC,
    parameter NLVL = `IWC_NLVL,
    parameter LVLW = `IWC_LVLW,
    parameter VECW = `IWC_VECW
) (
    input  wire [NSRC-1:0]      req,
    input  wire [NSRC*LVLW-1:0] prio,
    input  wire [NLVL-1:0]      insvc,
    output reg                  win,
    output reg  [VECW-1:0]      win_src,
    output reg  [LVLW-1:0]      win_lvl
);

    integer l;
    integer s;
    reg     found;

    // ---------------------------------------------------------------
    // highest level first, lowest source index within a level
    // ---------------------------------------------------------------
    always @* begin
        found   = 1'b0;
        win     = 1'b0;
        win_src = {VECW{1'b0}};
        win_lvl = {LVLW{1'b0}};
        for (l = NLVL - 1; l >= 0; l = l - 1) begin
            // a level at or below one in service cannot preempt
            if (!found && (insvc >> l) == {NLVL{1'b0}}) begin
                for (s = 0; s < NSRC; s = s + 1) begin
                    if (!found && req[s] &&
                        prio[s*LVLW +: LVLW] == l[LVLW-1:0]) begin
                        found   = 1'b1;
                        win     = 1'b1;
                        win_src = s[VECW-1:0];
                        win_lvl = l[LVLW-1:0];
                    end
                end
            end
        end
    end

endmodule

// ==== iwc_top.v ====
// interrupt and wake controller: flags, enables, arbitration, power modes
//
// Functional notes
// - eleven request sources are ranked into four selectable levels.
// - each source has its own pending flag, readable in one register.
// - a source is forwarded only while its own enable bit is set.
// - eight external inputs are synchronised and edge or level checked.
// - two inputs request on falling edge or while held low, selectable.
// - two inputs request on rising or on falling edge, selectable.
// - four inputs request on rising edge only.
// - idle stops the processor clock while peripheral clocks run.
// - idle ends on any enabled pending request or on reset.
// - stop gates processor and peripheral clocks alike.
// - stop ends on reset or a clockless low level at an enabled level input.
// - all logic is synchronous to the rising edge with synchronous reset.
//
// Chosen here: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ns
`include "iwc_defs.vh"

module iwc_top #(
    parameter NSRC = `IWC_NSRC,
    parameter NEXT = `IWC_NEXT,
    parameter NLVL = `IWC_NLVL,
    parameter LVLW = `IWC_LVLW,
    parameter VECW = `IWC_VECW
) (
    input  wire                 clk,
    input  wire                 rst_n,
    // avalon-mm slave
    input  wire [4:0]           address,
    input  wire                 read,
    input  wire                 write,
    input  wire [31:0]          writedata,
    output reg  [31:0]          readdata,
    output wire                 waitrequest,
    // external interrupt pins
    input  wire [NEXT-1:0]      ext_int,
    // on-chip peripheral requests, same clock
    input  wire [NSRC-NEXT-1:0] periph_req,
    // processor core
    output reg                  cpu_irq,
    output reg  [VECW-1:0]      cpu_irq_vec,
    input  wire                 cpu_irq_ack,
    input  wire                 cpu_irq_ret,
    // clock gating
    output wire                 cpu_clk_en,
    output wire                 periph_clk_en,
    // status interrupt
    output wire                 pm_irq
);

    localparam NPER = NSRC - NEXT;
    localparam ST_RUN  = 2'b00;
    localparam ST_IDLE = 2'b01;
    localparam ST_STOP = 2'b10;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    reg  [NSRC-1:0]      en_r;
    reg  [NSRC*LVLW-1:0] prio_r;
    reg  [3:0]           cfg_r;
    reg  [1:0]           pm_r;
    reg  [1:0]           pm_nxt;
    reg  [NLVL-1:0]      insvc_r;
    reg  [`IWC_STW-1:0]  stat_r;
    reg  [`IWC_STW-1:0]  mask_r;
    reg                  ack_r;
    reg  [VECW-1:0]      svc_src_r;

    wire [NEXT-1:0]      ext_flag;
    wire [NEXT-1:0]      ext_lvl;
    reg  [NEXT-1:0]      ext_clr;
    wire [NSRC-1:0]      pend;
    wire [NSRC-1:0]      fwd;
    wire                 arb_win;
    wire [VECW-1:0]      arb_src;
    wire [LVLW-1:0]      arb_lvl;
    wire                 acc;
    wire                 wr_go;
    wire                 rd_go;
    wire                 stop_wake;
    wire                 idle_wake;
    reg  [31:0]          rd_mux;
    reg  [NLVL-1:0]      top_lvl;
    wire [NEXT-1:0]      ext_sel;
    wire [NLVL-1:0]      push_lvl;
    integer              i;
    integer              j;

    // ---------------------------------------------------------------
    // external input detectors
    // ---------------------------------------------------------------
    // select bits, zero above the four selectable inputs
    assign ext_sel = {{(NEXT-4){1'b0}}, cfg_r};

    genvar g;
    generate
        for (g = 0; g < NEXT; g = g + 1) begin : g_ext
            // inputs 0-1 low/fall, 2-3 rise/fall, the rest rise only
            iwc_extint_det #(
                .KIND (g < 2 ? `IWC_KIND_LOWFALL :
                       g < 4 ? `IWC_KIND_RISEFALL :
                               `IWC_KIND_RISE)
            ) u_det (
                .clk        (clk),
                .rst_n      (rst_n),
                .pin        (ext_int[g]),
                .sel        (ext_sel[g]),
                .clr        (ext_clr[g]),
                .flag       (ext_flag[g]),
                .level_mode (ext_lvl[g])
            );
        end
    endgenerate

    // pending flags: externals then peripheral levels
    assign pend = {periph_req, ext_flag};
    assign fwd  = pend & en_r;

    // ---------------------------------------------------------------
    // arbitration
    // ---------------------------------------------------------------
    iwc_prio_arb #(
        .NSRC (NSRC),
        .NLVL (NLVL),
        .LVLW (LVLW),
        .VECW (VECW)
    ) u_arb (
        .req     (fwd),
        .prio    (prio_r),
        .insvc   (insvc_r),
        .win     (arb_win),
        .win_src (arb_src),
        .win_lvl (arb_lvl)
    );

    // ---------------------------------------------------------------
    // bus handshake: one wait cycle per access
    // ---------------------------------------------------------------
    assign acc         = read | write;
    assign waitrequest = acc & ~ack_r;
    assign wr_go       = write & ack_r;
    assign rd_go       = read & ack_r;

    // edge flag clears: vectoring or software write-one
    always @* begin
        ext_clr = {NEXT{1'b0}};
        for (i = 0; i < NEXT; i = i + 1) begin
            if (cpu_irq_ack && svc_src_r == i[VECW-1:0])
                ext_clr[i] = 1'b1;
            if (wr_go && address == `IWC_ADDR_REQ && writedata[i])
                ext_clr[i] = 1'b1;
        end
    end

    // highest level now in service, as a one-hot mask
    always @* begin
        top_lvl = {NLVL{1'b0}};
        for (j = 0; j < NLVL; j = j + 1) begin
            if (insvc_r[j])
                top_lvl = {NLVL{1'b0}} | ({{(NLVL-1){1'b0}}, 1'b1} << j);
        end
    end

    // ---------------------------------------------------------------
    // power modes
    // ---------------------------------------------------------------
    // clockless wake: raw pin low on an enabled level-mode input
    assign stop_wake = |(~ext_int[1:0] & ext_lvl[1:0] & en_r[1:0]);
    assign idle_wake = |fwd;

    always @* begin
        pm_nxt = pm_r;
        case (pm_r)
            ST_RUN: begin
                if (wr_go && address == `IWC_ADDR_PMCTL) begin
                    if (writedata[`IWC_PM_STOP])
                        pm_nxt = ST_STOP;
                    else if (writedata[`IWC_PM_IDLE])
                        pm_nxt = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (idle_wake)
                    pm_nxt = ST_RUN;
            end
            ST_STOP: begin
                if (stop_wake)
                    pm_nxt = ST_RUN;
            end
            default: pm_nxt = ST_RUN;
        endcase
    end

    // idle halts the core only; stop halts both unless waking
    assign cpu_clk_en    = (pm_r == ST_RUN) | (pm_r == ST_STOP & stop_wake);
    assign periph_clk_en = (pm_r != ST_STOP) | stop_wake;

    // ---------------------------------------------------------------
    // read mux
    // ---------------------------------------------------------------
    always @* begin
        rd_mux = 32'h00000000;
        if (address == `IWC_ADDR_REQ)
            rd_mux[NSRC-1:0] = pend;
        else if (address == `IWC_ADDR_EN)
            rd_mux[NSRC-1:0] = en_r;
        else if (address == `IWC_ADDR_PRIO)
            rd_mux[NSRC*LVLW-1:0] = prio_r;
        else if (address == `IWC_ADDR_EXTCFG)
            rd_mux[3:0] = cfg_r;
        else if (address == `IWC_ADDR_PMCTL)
            rd_mux[1:0] = pm_r;
        else if (address == `IWC_ADDR_INSVC)
            rd_mux[NLVL-1:0] = insvc_r;
        else if (address == `IWC_ADDR_STAT)
            rd_mux[`IWC_STW-1:0] = stat_r;
        else if (address == `IWC_ADDR_MASK)
            rd_mux[`IWC_STW-1:0] = mask_r;
    end

    assign pm_irq = |(stat_r & mask_r);

    // ---------------------------------------------------------------
    // bus and configuration registers, synchronous reset
    // ---------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            ack_r    <= 1'b0;
            readdata <= 32'h00000000;
            en_r     <= `IWC_EN_RST;
            prio_r   <= `IWC_PRIO_RST;
            cfg_r    <= `IWC_CFG_RST;
            mask_r   <= `IWC_MASK_RST;
        end else begin
            // one wait cycle, read data captured while waiting
            ack_r <= acc & ~ack_r;
            if (acc && !ack_r)
                readdata <= rd_mux;
            // writes land at the edge that ends the cycle after the wait cycle
            if (wr_go) begin
                if (address == `IWC_ADDR_EN)
                    en_r <= writedata[NSRC-1:0];
                else if (address == `IWC_ADDR_PRIO)
                    prio_r <= writedata[NSRC*LVLW-1:0];
                else if (address == `IWC_ADDR_EXTCFG)
                    cfg_r <= writedata[3:0];
                else if (address == `IWC_ADDR_MASK)
                    mask_r <= writedata[`IWC_STW-1:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // power mode and wake status
    // ---------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            pm_r   <= ST_RUN;
            stat_r <= {`IWC_STW{1'b0}};
        end else begin
            pm_r <= pm_nxt;
            // wake events: set wins over the read clear
            stat_r <= (rd_go && address == `IWC_ADDR_STAT) ?
                      {`IWC_STW{1'b0}} : stat_r;
            if (pm_r == ST_IDLE && idle_wake)
                stat_r[`IWC_ST_WIDLE] <= 1'b1;
            if (pm_r == ST_STOP && stop_wake)
                stat_r[`IWC_ST_WSTOP] <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // core request and in-service levels
    // ---------------------------------------------------------------
    // one-hot level of the source being vectored
    assign push_lvl = {{(NLVL-1){1'b0}}, 1'b1}
                      << prio_r[svc_src_r*LVLW +: LVLW];

    always @(posedge clk) begin
        if (!rst_n) begin
            cpu_irq     <= 1'b0;
            cpu_irq_vec <= {VECW{1'b0}};
            svc_src_r   <= {VECW{1'b0}};
            insvc_r     <= {NLVL{1'b0}};
        end else begin
            // request to the core, held stable while raised
            if (!cpu_irq || cpu_irq_ack) begin
                cpu_irq     <= arb_win & ~cpu_irq_ack;
                cpu_irq_vec <= arb_src;
                svc_src_r   <= arb_src;
            end
            // in-service levels: set at vectoring, pop at return
            if (cpu_irq && cpu_irq_ack)
                insvc_r <= (insvc_r & ~(cpu_irq_ret ? top_lvl
                                                    : {NLVL{1'b0}}))
                         | push_lvl;
            else if (cpu_irq_ret)
                insvc_r <= insvc_r & ~top_lvl;
        end
    end

endmodule

// ==== test_interrupt_and_wake_controller.sv ====
// self-checking bench for the interrupt and wake controller
`timescale 1ns/1ns
`include "iwc_defs.vh"
module test_interrupt_and_wake_controller;
    logic        clk, rst_n, read, write, waitrequest, seen;
    logic        cpu_irq, cpu_irq_ack, cpu_irq_ret, cpu_clk_en;
    logic        periph_clk_en, pm_irq;
    logic [4:0]  address;
    logic [31:0] writedata, readdata, rd;
    logic [7:0]  ext_int, ret_wait;
    logic [2:0]  periph_req;
    logic [3:0]  cpu_irq_vec, ack_wait;
    int          failures = 0, n_compared = 0, cycles = 0;
    // steps as 12'hEVS: expected pending, pin level, pin index
    logic [11:0] tbl0 [16] = '{12'h100, 12'h010, 12'h101, 12'h011,
        12'h102, 12'h012, 12'h103, 12'h013, 12'h114, 12'h004,
        12'h115, 12'h005, 12'h116, 12'h006, 12'h117, 12'h007};
    logic [11:0] tbl1 [9] = '{12'h100, 12'h100, 12'h010, 12'h101,
        12'h011, 12'h002, 12'h112, 12'h003, 12'h113};
    iwc_top i_iwc_top (.clk(clk), .rst_n(rst_n), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest),
        .ext_int(ext_int), .periph_req(periph_req), .cpu_irq(cpu_irq),
        .cpu_irq_vec(cpu_irq_vec), .cpu_irq_ack(cpu_irq_ack),
        .cpu_irq_ret(cpu_irq_ret), .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph_clk_en), .pm_irq(pm_irq));
    iwc_core_model i_iwc_core_model (.clk(clk), .rst_n(rst_n),
        .cpu_irq(cpu_irq), .run(cpu_clk_en), .ack_wait(ack_wait),
        .ret_wait(ret_wait), .ack(cpu_irq_ack), .ret(cpu_irq_ret));
    // ----------------
    // clock and limits
    // ----------------
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    // cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            close_out;
        end
    end
    task close_out;
        if (failures == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one avalon access, entered just after a rising edge
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        read <= ~w;
        write <= w;
        @(posedge clk);
        while (waitrequest !== 1'h0) @(posedge clk);
        rd = readdata;
        read <= 1'h0;
        write <= 1'h0;
        @(posedge clk);
    endtask
    task rdchk(input logic [4:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        chk(rd, e);
    endtask
    // wait for a core request, check its source, wait until taken
    task wirq(input logic [3:0] v);
        @(negedge clk);
        repeat (80) if (cpu_irq !== 1'h1) @(negedge clk);
        chk(cpu_irq, 32'h1);
        chk(cpu_irq_vec, v);
        while (cpu_irq === 1'h1) @(negedge clk);
        @(posedge clk);
    endtask
    // move one pin, look at the pending flags, then clear edge flags
    task trig(input logic [11:0] t);
        ext_int[t[2:0]] <= t[4];
        repeat (6) @(posedge clk);
        rdchk(`IWC_ADDR_REQ, {31'h0, t[8]} << t[2:0]);
        bus(1'h1, `IWC_ADDR_REQ, 32'hFF);
    endtask
    // main sequence
    initial begin
        {rst_n, read, write, address, writedata, periph_req} = '0;
        ext_int = 8'h0F;
        ack_wait = 4'h1;
        ret_wait = 8'h08;
        repeat (5) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        rdchk(`IWC_ADDR_EN, `IWC_EN_RST);
        rdchk(`IWC_ADDR_PRIO, `IWC_PRIO_RST);
        rdchk(`IWC_ADDR_EXTCFG, `IWC_CFG_RST);
        rdchk(`IWC_ADDR_MASK, `IWC_MASK_RST);
        bus(1'h1, 5'h1E, 32'hFFFFFFFF);
        rdchk(5'h1E, 32'h0);
        bus(1'h1, `IWC_ADDR_PRIO, 32'h00100000);
        rdchk(`IWC_ADDR_PRIO, 32'h00100000);
        foreach (tbl0[k]) trig(tbl0[k]);
        bus(1'h1, `IWC_ADDR_EXTCFG, 32'hF);
        foreach (tbl1[k]) trig(tbl1[k]);
        bus(1'h1, `IWC_ADDR_EN, 32'h7FF);
        for (int k = 4; k < 8; k++) begin
            ext_int[k] <= 1'h1;
            wirq(k[3:0]);
            ext_int[k] <= 1'h0;
            rdchk(`IWC_ADDR_REQ, 32'h0);
        end
        ack_wait <= 4'h4;
        periph_req <= 3'h3;
        wirq(4'h8);
        periph_req <= 3'h2;
        wirq(4'h9);
        periph_req <= 3'h0;
        ret_wait <= 8'h28;
        repeat (12) @(posedge clk);
        periph_req <= 3'h1;
        wirq(4'h8);
        periph_req <= 3'h2;
        seen = 1'h0;
        repeat (10) begin
            @(negedge clk);
            seen = seen | cpu_irq;
        end
        chk(seen, 32'h0);
        @(posedge clk);
        periph_req <= 3'h6;
        wirq(4'hA);
        periph_req <= 3'h0;
        rdchk(`IWC_ADDR_INSVC, 32'h3);
        repeat (100) @(posedge clk);
        rdchk(`IWC_ADDR_INSVC, 32'h0);
        ret_wait <= 8'h08;
        bus(1'h1, `IWC_ADDR_MASK, 32'h3);
        bus(1'h1, `IWC_ADDR_EN, 32'h3FF);
        bus(1'h1, `IWC_ADDR_PMCTL, 32'h1);
        rdchk(`IWC_ADDR_PMCTL, 32'h1);
        periph_req <= 3'h4;
        repeat (10) @(negedge clk);
        chk({cpu_clk_en, periph_clk_en}, 32'h1);
        @(posedge clk);
        bus(1'h1, `IWC_ADDR_EN, 32'h7FF);
        wirq(4'hA);
        periph_req <= 3'h0;
        chk(pm_irq, 32'h1);
        rdchk(`IWC_ADDR_STAT, 32'h1);
        chk(pm_irq, 32'h0);
        repeat (12) @(posedge clk);
        bus(1'h1, `IWC_ADDR_PMCTL, 32'h2);
        repeat (10) @(negedge clk);
        chk({cpu_clk_en, periph_clk_en}, 32'h0);
        @(posedge clk);
        ext_int[0] <= 1'h0;
        @(negedge clk);
        chk({cpu_clk_en, periph_clk_en}, 32'h3);
        wirq(4'h0);
        ext_int[0] <= 1'h1;
        rdchk(`IWC_ADDR_STAT, 32'h2);
        rdchk(`IWC_ADDR_PMCTL, 32'h0);
        close_out;
    end
endmodule
bind iwc_top iwc_monitor #(.NSRC(NSRC), .NEXT(NEXT), .VECW(VECW))
    i_iwc_monitor (.clk(clk), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .ext_int(ext_int),
    .periph_req(periph_req), .cpu_irq(cpu_irq),
    .cpu_irq_vec(cpu_irq_vec), .cpu_irq_ack(cpu_irq_ack),
    .cpu_irq_ret(cpu_irq_ret), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .pm_irq(pm_irq));
